// ### lcl_pkg.sv
package lcl_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [2:0] LCL_OFF_CONL = 3'h0;
  localparam logic [2:0] LCL_OFF_CONH = 3'h1;
  localparam logic [2:0] LCL_OFF_SEL = 3'h2;
  localparam logic [2:0] LCL_OFF_GLSL = 3'h3;
  localparam logic [2:0] LCL_OFF_GLSH = 3'h4;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int LCL_BIT_EN = 15;
  localparam int LCL_BIT_RISE = 11;
  localparam int LCL_BIT_FALL = 10;
  localparam int LCL_BIT_OE = 7;
  localparam int LCL_BIT_LVL = 6;
  localparam int LCL_BIT_INV = 5;
  localparam int LCL_MODE_LSB = 0;
  localparam int LCL_MODE_W = 3;
  localparam int LCL_SEL_STRIDE = 4;

  // ----------------------------------------
  // Write masks and reset values
  // ----------------------------------------
  localparam logic [15:0] LCL_CONL_WMASK = 16'h8ca7;
  localparam logic [15:0] LCL_CONH_WMASK = 16'h000f;
  localparam logic [15:0] LCL_SEL_WMASK = 16'h7777;
  localparam logic [15:0] LCL_GLS_WMASK = 16'hffff;
  localparam logic [15:0] LCL_REG_RST = 16'h0000;

  // ----------------------------------------
  // Logic function codes
  // ----------------------------------------
  localparam logic [2:0] LCL_MODE_ANDOR = 3'h0;
  localparam logic [2:0] LCL_MODE_ORXOR = 3'h1;
  localparam logic [2:0] LCL_MODE_AND = 3'h2;
  localparam logic [2:0] LCL_MODE_SRL = 3'h3;
  localparam logic [2:0] LCL_MODE_DFFSR = 3'h4;
  localparam logic [2:0] LCL_MODE_DFF2R = 3'h5;
  localparam logic [2:0] LCL_MODE_JKR = 3'h6;
  localparam logic [2:0] LCL_MODE_LATSR = 3'h7;

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  localparam int LCL_ASYNC_N = 6;

endpackage

// ### lcl_gate_if.sv
`timescale 1ns/1ps
interface lcl_gate_if;
  logic [15:0] sel;
  logic [31:0] gate_en;
  logic [3:0] gate_inv;
  logic [31:0] src;
  logic [3:0] gate;

  modport gates (
    input sel,
    input gate_en,
    input gate_inv,
    input src,
    output gate
  );

  modport core (
    output sel,
    output gate_en,
    output gate_inv,
    output src,
    input gate
  );
endinterface

// ### lcl_gates.sv
`timescale 1ns/1ps
module lcl_gates
  import lcl_pkg::*;
(
  lcl_gate_if.gates gif
);

  logic [3:0] mux_out;

  // ----------------------------------------
  // Source multiplexers
  // ----------------------------------------
  genvar m;
  generate
    for (m = 0; m < 4; m++) begin : g_mux
      assign mux_out[m] = gif.src[m*8 + gif.sel[m*LCL_SEL_STRIDE +: 3]];
    end
  endgenerate

  // ----------------------------------------
  // Input gates
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_gate
      logic [7:0] en;
      logic hit;
      assign en = gif.gate_en[g*8 +: 8];
      // odd bit true, even bit inverted
      always_comb begin
        hit = 1'b0;
        for (int s = 0; s < 4; s++) begin
          hit = hit | (en[2*s+1] & mux_out[s]) | (en[2*s] & ~mux_out[s]);
        end
      end
      assign gif.gate[g] = hit ^ gif.gate_inv[g];
    end
  endgenerate

endmodule

// ### lcl_cell.sv
// Operation
// - Four muxes, each picks one of eight
// - True and inverted mux outputs ORed per gate
// - Empty gate gives zero, or one inverted
// - Per gate polarity bits three down to zero
// - Enable clear forces output, pin and rise request low
// - Rise enable requests interrupt on rising output
// - Fall enable requests interrupt on falling output
// - Pin driven only while output enable set
// - Status bit shows present output level
// - Codes zero to three: combinational and SR
// - Codes four to seven: flops and latch
// - Mux one source map
// - Mux three source map
// - True and inverted enables, 32 bits
// - Unused bits read zero, fields reset zero
`timescale 1ns/1ps
module lcl_cell
  import lcl_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic cell_input_pin_a_i,
  input wire logic cell_input_pin_b_i,
  input wire logic cell_input_pin_c_i,
  input wire logic cell_input_pin_d_i,
  input wire logic instruction_clock_i,
  input wire logic internal_lowpower_osc_i,
  input wire logic reference_clock_out_i,
  input wire logic pwm_event_i,
  input wire logic [2:0] comparator_i,
  input wire logic uart_tx_i,
  input wire logic uart_rx_i,
  input wire logic spi_sdo_i,
  input wire logic spi_sdi_i,
  input wire logic [3:0] peer_cell_i,
  input wire logic [3:0] capture_compare_unit_aux_i,
  input wire logic [1:0] capture_compare_unit_out_i,
  input wire logic [1:0] capture_compare_unit_flag_i,
  output logic cell_output_o,
  output logic cell_pin_o,
  output logic pin_output_enable_o,
  output logic rise_irq_o,
  output logic fall_irq_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  lcl_gate_if gif ();

  logic [15:0] conl_q, conl_d;
  logic [15:0] conh_q, conh_d;
  logic [15:0] sel_q, sel_d;
  logic [15:0] glsl_q, glsl_d;
  logic [15:0] glsh_q, glsh_d;
  logic [15:0] rdata_q, rdata_d;

  logic [LCL_ASYNC_N-1:0] async_in;
  logic [LCL_ASYNC_N-1:0] s1_q, s2_q, s3_q;
  logic [LCL_ASYNC_N-1:0] flt_q, flt_d;

  logic [3:0] g;
  logic [2:0] mode;
  logic cell_en;
  logic state_q, state_d;
  logic clk_prev_q, clk_prev_d;
  logic clk_edge;
  logic res;
  logic out_q, out_d;
  logic pin_q, pin_d;
  logic oe_q, oe_d;
  logic rise_q, rise_d;
  logic fall_q, fall_d;

  // ----------------------------------------
  // Pin and foreign clock synchronisers
  // ----------------------------------------
  assign async_in = {reference_clock_out_i, internal_lowpower_osc_i, cell_input_pin_d_i,
                     cell_input_pin_c_i, cell_input_pin_b_i, cell_input_pin_a_i};

  // Filtered level follows once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < LCL_ASYNC_N; i++) begin : g_flt
      assign flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
    end
  endgenerate

  // Three stage chain
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      flt_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
    end
  end

  // ----------------------------------------
  // Source pool
  // ----------------------------------------
  // mux one to four sources
  assign gif.src = {
    capture_compare_unit_aux_i[2], capture_compare_unit_aux_i[0], flt_q[3], 1'b0,
    spi_sdi_i, comparator_i[2], peer_cell_i[1], pwm_event_i,
    capture_compare_unit_flag_i[1], capture_compare_unit_flag_i[0], peer_cell_i[3], uart_rx_i,
    spi_sdo_i, comparator_i[1], peer_cell_i[0], flt_q[2],
    capture_compare_unit_out_i[1], capture_compare_unit_out_i[0], 1'b0, 1'b0,
    uart_tx_i, comparator_i[0], 1'b0, flt_q[1],
    capture_compare_unit_aux_i[3], capture_compare_unit_aux_i[1], 1'b0, flt_q[5],
    flt_q[4], peer_cell_i[2], instruction_clock_i, flt_q[0]
  };

  // Gate configuration towards the gate block
  assign gif.sel = sel_q;
  assign gif.gate_en = {glsh_q, glsl_q};
  assign gif.gate_inv = conh_q[3:0];

  lcl_gates u_gates (
    .gif(gif)
  );

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // masked writes and zero fill
  always_comb begin
    conl_d = conl_q;
    conh_d = conh_q;
    sel_d = sel_q;
    glsl_d = glsl_q;
    glsh_d = glsh_q;
    rdata_d = '0;
    if (wr_i) begin
      case (addr_i)
        LCL_OFF_CONL: begin
          conl_d = wdata_i & LCL_CONL_WMASK;
        end
        LCL_OFF_CONH: begin
          conh_d = wdata_i & LCL_CONH_WMASK;
        end
        LCL_OFF_SEL: begin
          sel_d = wdata_i & LCL_SEL_WMASK;
        end
        LCL_OFF_GLSL: begin
          glsl_d = wdata_i & LCL_GLS_WMASK;
        end
        LCL_OFF_GLSH: begin
          glsh_d = wdata_i & LCL_GLS_WMASK;
        end
        default: begin
          conl_d = conl_q;
        end
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        LCL_OFF_CONL: begin
          rdata_d = conl_q;
          rdata_d[LCL_BIT_LVL] = out_q;
        end
        LCL_OFF_CONH: begin
          rdata_d = conh_q;
        end
        LCL_OFF_SEL: begin
          rdata_d = sel_q;
        end
        LCL_OFF_GLSL: begin
          rdata_d = glsl_q;
        end
        LCL_OFF_GLSH: begin
          rdata_d = glsh_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conl_q <= LCL_REG_RST;
      conh_q <= LCL_REG_RST;
      sel_q <= LCL_REG_RST;
      glsl_q <= LCL_REG_RST;
      glsh_q <= LCL_REG_RST;
      rdata_q <= LCL_REG_RST;
    end else begin
      conl_q <= conl_d;
      conh_q <= conh_d;
      sel_q <= sel_d;
      glsl_q <= glsl_d;
      glsh_q <= glsh_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Logic function
  // ----------------------------------------
  assign g = gif.gate;
  assign mode = conl_q[LCL_MODE_LSB +: LCL_MODE_W];
  assign cell_en = conl_q[LCL_BIT_EN];
  assign clk_edge = g[0] & ~clk_prev_q;

  // codes four and seven: gate one clocks, two data, three reset, four set
  always_comb begin
    state_d = state_q;
    clk_prev_d = g[0];
    res = 1'b0;
    case (mode)
      LCL_MODE_ANDOR: begin
        res = (g[0] & g[1]) | (g[2] & g[3]);
      end
      LCL_MODE_ORXOR: begin
        res = (g[0] | g[1]) ^ (g[2] | g[3]);
      end
      LCL_MODE_AND: begin
        res = &g;
      end
      LCL_MODE_SRL: begin
        if (g[0] | g[1]) begin
          state_d = 1'b1;
        end else if (g[2] | g[3]) begin
          state_d = 1'b0;
        end
        res = state_d;
      end
      LCL_MODE_DFFSR: begin
        if (g[2]) begin
          state_d = 1'b0;
        end else if (g[3]) begin
          state_d = 1'b1;
        end else if (clk_edge) begin
          state_d = g[1];
        end
        res = state_d;
      end
      LCL_MODE_DFF2R: begin
        if (g[2]) begin
          state_d = 1'b0;
        end else if (clk_edge) begin
          state_d = g[1] & g[3];
        end
        res = state_d;
      end
      LCL_MODE_JKR: begin
        if (g[2]) begin
          state_d = 1'b0;
        end else if (clk_edge) begin
          case ({g[1], g[3]})
            2'b10: begin
              state_d = 1'b1;
            end
            2'b01: begin
              state_d = 1'b0;
            end
            2'b11: begin
              state_d = ~state_q;
            end
            default: begin
              state_d = state_q;
            end
          endcase
        end
        res = state_d;
      end
      LCL_MODE_LATSR: begin
        if (g[2]) begin
          state_d = 1'b0;
        end else if (g[3]) begin
          state_d = 1'b1;
        end else if (g[0]) begin
          state_d = g[1];
        end
        res = state_d;
      end
      default: begin
        res = 1'b0;
      end
    endcase
    if (!cell_en) begin
      state_d = 1'b0;
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  always_comb begin
    out_d = cell_en & (res ^ conl_q[LCL_BIT_INV]);
    oe_d = conl_q[LCL_BIT_OE];
    pin_d = conl_q[LCL_BIT_OE] & out_d;
    rise_d = conl_q[LCL_BIT_RISE] & out_d & ~out_q;
    fall_d = conl_q[LCL_BIT_FALL] & ~out_d & out_q;
  end

  // Output and function state flops
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= 1'b0;
      clk_prev_q <= 1'b0;
      out_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      state_q <= state_d;
      clk_prev_q <= clk_prev_d;
      out_q <= out_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign rdata_o = rdata_q;
  assign cell_output_o = out_q;
  assign cell_pin_o = pin_q;
  assign pin_output_enable_o = oe_q;
  assign rise_irq_o = rise_q;
  assign fall_irq_o = fall_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  a_disable_out_low: assert property (!cell_en |=> !cell_output_o && !rise_irq_o)
    else $error("Disabled cell output not low");
  a_rise_irq_cause: assert property (rise_irq_o |-> $past(conl_q[LCL_BIT_RISE]) && cell_output_o
    && !$past(cell_output_o))
    else $error("Rise request without rising edge");
  a_fall_irq_cause: assert property (fall_irq_o |-> $past(conl_q[LCL_BIT_FALL]) && !cell_output_o
    && $past(cell_output_o))
    else $error("Fall request without falling edge");
  a_pin_gated_oe: assert property (cell_pin_o |-> pin_output_enable_o && cell_output_o)
    else $error("Pin driven without enable");
  a_status_level: assert property (rd_i && addr_i == LCL_OFF_CONL
    |=> rdata_o[LCL_BIT_LVL] == $past(cell_output_o))
    else $error("Status bit differs from output");
  a_and_invert: assert property (cell_en && mode == LCL_MODE_AND && conl_q[LCL_BIT_INV]
    |=> cell_output_o == !$past(&g))
    else $error("Inverted AND output wrong");
  a_andor_func: assert property (cell_en && mode == LCL_MODE_ANDOR && !conl_q[LCL_BIT_INV]
    |=> cell_output_o == $past((g[0] & g[1]) | (g[2] & g[3])))
    else $error("AND-OR output wrong");
  a_jk_reset_low: assert property (cell_en && mode == LCL_MODE_JKR && g[2] && !conl_q[LCL_BIT_INV]
    |=> !cell_output_o)
    else $error("JK reset ignored");
  a_empty_gate: assert property (glsl_q[7:0] == 8'h00 |-> g[0] == conh_q[0])
    else $error("Empty gate not at polarity level");
  a_reserved_zero: assert property (rd_i && addr_i == LCL_OFF_CONH |=> rdata_o[15:4] == 12'h000)
    else $error("Reserved bits not zero");

  c_rise_irq: cover property (rise_irq_o);
  c_fall_irq: cover property (fall_irq_o);
  c_dff_capture: cover property (cell_en && mode == LCL_MODE_DFFSR && clk_edge && g[1] ##1 cell_output_o);
  c_pin_drive: cover property (cell_pin_o);

endmodule

// ### lcl_src_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-side source model
// ----------------------------------------
module lcl_src_model (
  input wire logic [31:0] slot_i,
  output logic [3:0] pin_o,
  output logic [2:0] clk_src_o,
  output logic [4:0] bus_sig_o,
  output logic [2:0] comp_o,
  output logic [3:0] peer_o,
  output logic [3:0] aux_o,
  output logic [1:0] ccu_out_o,
  output logic [1:0] ccu_flag_o
);
  // Each source follows its slot, slot is mux times eight plus code
  assign pin_o = {slot_i[29], slot_i[16], slot_i[8], slot_i[0]};
  assign clk_src_o = {slot_i[4], slot_i[3], slot_i[1]};
  assign bus_sig_o = {slot_i[27], slot_i[19], slot_i[20], slot_i[11], slot_i[24]};
  assign comp_o = {slot_i[26], slot_i[18], slot_i[10]};
  assign peer_o = {slot_i[21], slot_i[2], slot_i[25], slot_i[17]};
  assign aux_o = {slot_i[7], slot_i[31], slot_i[6], slot_i[30]};
  assign ccu_out_o = {slot_i[15], slot_i[14]};
  assign ccu_flag_o = {slot_i[23], slot_i[22]};
endmodule

// ### tb_lcl_cell.sv
`timescale 1ns/1ps
module tb_lcl_cell
  import lcl_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] slot = 32'h0;
  logic [15:0] rdata;
  logic c_out, c_pin, c_oe, r_irq, f_irq;
  logic [3:0] pin, peer, aux;
  logic [2:0] clks, comp;
  logic [4:0] bus;
  logic [1:0] cco, ccf;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_rise = 0;
  int n_fall = 0;
  logic [7:0] seq [33] = '{8'h63, 8'h61, 8'h68, 8'h60, 8'h6b, 8'h88, 8'h84, 8'h87, 8'h83, 8'h81, 8'h82,
    8'h91, 8'h98, 8'ha8, 8'hb4, 8'hb7, 8'ha5, 8'ha6, 8'hc8, 8'hc4, 8'hc7, 8'hd1, 8'hd2, 8'hd4, 8'hd7,
    8'hd5, 8'hd6, 8'he8, 8'he7, 8'he2, 8'he4, 8'hf1, 8'hf8};

  // ----------------------------------------
  // Clock, watchdog and pulse counters
  // ----------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (r_irq === 1'b1) n_rise++;
    if (f_irq === 1'b1) n_fall++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("BAD %0t run too long", $time);
      close_out();
    end
  end

  lcl_src_model src_u (.slot_i(slot), .pin_o(pin), .clk_src_o(clks), .bus_sig_o(bus), .comp_o(comp),
    .peer_o(peer), .aux_o(aux), .ccu_out_o(cco), .ccu_flag_o(ccf));

  lcl_cell dut_u (.clock_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .cell_input_pin_a_i(pin[0]), .cell_input_pin_b_i(pin[1]), .cell_input_pin_c_i(pin[2]),
    .cell_input_pin_d_i(pin[3]), .instruction_clock_i(clks[0]), .internal_lowpower_osc_i(clks[1]),
    .reference_clock_out_i(clks[2]), .pwm_event_i(bus[0]), .comparator_i(comp), .uart_tx_i(bus[1]),
    .uart_rx_i(bus[2]), .spi_sdo_i(bus[3]), .spi_sdi_i(bus[4]), .peer_cell_i(peer),
    .capture_compare_unit_aux_i(aux), .capture_compare_unit_out_i(cco), .capture_compare_unit_flag_i(ccf),
    .cell_output_o(c_out), .cell_pin_o(c_pin), .pin_output_enable_o(c_oe), .rise_irq_o(r_irq),
    .fall_irq_o(f_irq));

  // ----------------------------------------
  // Bus, stimulus and compare tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s is %b", $time, what, got);
    end
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_reg(rdata, exp);
  endtask

  task automatic hold(input logic [31:0] s);
    @(posedge clk);
    slot <= s;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // Gate g is fed by mux g at code two
  task automatic set_g(input logic [3:0] g);
    hold({5'h0, g[3], 7'h0, g[2], 7'h0, g[1], 7'h0, g[0], 2'h0});
  endtask

  function automatic logic fn(input logic [2:0] m, input logic [3:0] g);
    case (m)
      3'h0: fn = (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: fn = (g[0] | g[1]) ^ (g[2] | g[3]);
      default: fn = &g;
    endcase
  endfunction

  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] mexp [6];
    logic [15:0] cl, sv;
    logic e;
    int idx;
    mexp = '{16'h7fff & LCL_CONL_WMASK, LCL_CONH_WMASK, LCL_SEL_WMASK, 16'hffff, 16'hffff, 16'h0};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(i[2:0], 16'h0);
    for (int i = 0; i < 6; i++) wr_reg(i[2:0], (i == 0) ? 16'h7fff : 16'hffff);
    for (int i = 0; i < 6; i++) rd_chk(i[2:0], mexp[i]);
    chk_bit(c_oe, 1'b1, "port enable");
    chk_bit(c_out | c_pin, 1'b0, "disabled output");
    for (int i = 0; i < 5; i++) wr_reg(i[2:0], 16'h0);
    $display("test registers done");
    // Combinational modes with both polarity settings
    wr_reg(LCL_OFF_SEL, 16'h2222);
    wr_reg(LCL_OFF_GLSL, 16'h0802);
    wr_reg(LCL_OFF_GLSH, 16'h8020);
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 2; p++) begin
        wr_reg(LCL_OFF_CONH, (p == 1) ? 16'h000a : 16'h0);
        cl = {1'b1, 9'h0, p[0], 2'h0, m[2:0]};
        wr_reg(LCL_OFF_CONL, cl);
        for (int v = 0; v < 16; v++) begin
          set_g(v[3:0]);
          e = fn(m[2:0], v[3:0] ^ ((p == 1) ? 4'ha : 4'h0)) ^ p[0];
          chk_bit(c_out, e, "logic output");
          rd_chk(LCL_OFF_CONL, cl | {9'h0, e, 6'h0});
        end
      end
    end
    $display("test combinational done");
    // Empty gates and inverted sources
    wr_reg(LCL_OFF_CONH, 16'h0);
    wr_reg(LCL_OFF_GLSL, 16'h0);
    wr_reg(LCL_OFF_GLSH, 16'h0);
    wr_reg(LCL_OFF_CONL, 16'h8002);
    set_g(4'hf);
    chk_bit(c_out, 1'b0, "empty gates");
    wr_reg(LCL_OFF_CONH, 16'h000f);
    set_g(4'h0);
    chk_bit(c_out, 1'b1, "empty inverted gates");
    wr_reg(LCL_OFF_CONH, 16'h0);
    wr_reg(LCL_OFF_GLSL, 16'h0401);
    wr_reg(LCL_OFF_GLSH, 16'h4010);
    set_g(4'h0);
    chk_bit(c_out, 1'b1, "inverted sources");
    set_g(4'h4);
    chk_bit(c_out, 1'b0, "inverted sources");
    $display("test empty gates done");
    // Edge requests, pin drive and disable
    wr_reg(LCL_OFF_GLSL, 16'h0802);
    wr_reg(LCL_OFF_GLSH, 16'h8020);
    for (int k = 0; k < 3; k++) begin
      cl = (k == 0) ? 16'h8c80 : ((k == 1) ? 16'h8880 : 16'h8480);
      wr_reg(LCL_OFF_CONL, cl);
      set_g(4'h0);
      n_rise = 0;
      n_fall = 0;
      set_g(4'h3);
      chk_bit(c_pin, 1'b1, "pin value");
      set_g(4'h0);
      chk_reg(n_rise[15:0], {15'h0, cl[11]});
      chk_reg(n_fall[15:0], {15'h0, cl[10]});
    end
    set_g(4'h3);
    wr_reg(LCL_OFF_CONL, 16'h0080);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(c_out | c_pin, 1'b0, "disabled output");
    wr_reg(LCL_OFF_CONL, 16'h8000);
    set_g(4'h3);
    chk_bit(c_out, 1'b1, "output level");
    chk_bit(c_oe | c_pin, 1'b0, "pin released");
    $display("test edges and pin done");
    // Sequential modes from the step table
    for (int i = 0; i < 33; i++) begin
      if (i == 0 || seq[i][7:5] != seq[i - 1][7:5]) wr_reg(LCL_OFF_CONL, {1'b1, 12'h0, seq[i][7:5]});
      set_g(seq[i][4:1]);
      chk_bit(c_out, seq[i][0], "stored output");
    end
    $display("test sequential done");
    // Every code of every mux, selected source alone high then alone low
    wr_reg(LCL_OFF_CONL, 16'h8001);
    wr_reg(LCL_OFF_GLSH, 16'h0);
    for (int k = 0; k < 4; k++) begin
      wr_reg(LCL_OFF_GLSL, 16'h2 << (2 * k));
      for (int c = 0; c < 8; c++) begin
        sv = 16'h0;
        sv[4 * k +: 3] = c[2:0];
        wr_reg(LCL_OFF_SEL, sv);
        idx = 8 * k + c;
        e = !(idx == 5 || idx == 9 || idx == 12 || idx == 13 || idx == 28);
        hold(32'h1 << idx);
        chk_bit(c_out, e, "selected source");
        hold(~(32'h1 << idx));
        chk_bit(c_out, 1'b0, "selected source low");
      end
    end
    $display("test mux codes done");
    // Second reset in mid-run
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    rd_chk(LCL_OFF_CONL, 16'h0);
    rd_chk(LCL_OFF_SEL, 16'h0);
    chk_bit(c_out, 1'b0, "output after reset");
    $display("test second reset done");
    close_out();
  end
endmodule
